// ===== core/i2c_interrupt_status_mask.sv
`timescale 1ns/1ps
// Behaviour
// - Threshold flag bit 2 high while buffer level is at or above threshold.
// - Enable bit 0 low flushes buffer and clears threshold flag at once.
// - Byte arriving into full 32-entry buffer sets overflow bit 1, byte dropped.
// - Overflow and underflow hold while disabled, clear when internal enable drops.
// - Reading data/command register with empty buffer sets underflow bit 0.
// - Twelve-bit read/write mask, one bit per event at same position.
// - Mask resets with bits 10..8 zero, bits 11 and 7..0 one.
// - General call bit 11 set on acknowledged general call, cleared by disable/read.
// - Start bit 10 set on any START or repeated START, master or slave.
// - Stop bit 9 set on any STOP, master or slave.
module i2c_interrupt_status_mask
  import i2c_evt_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [REG_W-1:0] i_reg_wdata,
  output logic [REG_W-1:0] o_reg_rdata,
  // Controller control
  input wire logic i_ctrl_enable,
  input wire logic i_engines_idle,
  input wire logic [LVL_W-1:0] i_receive_threshold_level,
  output logic o_internal_enable_signal,
  // Receive path
  input wire logic i_rx_byte_valid,
  input wire logic [BYTE_W-1:0] i_rx_byte,
  input wire logic i_data_command_register_rd,
  output logic [BYTE_W-1:0] o_rx_data,
  // Bus condition events
  input wire logic i_general_call_ack,
  input wire logic i_start_condition,
  input wire logic i_stop_condition,
  input wire logic i_general_call_clear_register_rd,
  input wire logic i_start_clear_rd,
  input wire logic i_stop_clear_rd,
  // Transmit side raw events, bits 8..3
  input wire logic [TX_SIDE_W-1:0] i_tx_side_raw,
  // Interrupt and receive level
  output logic o_irq,
  output logic [LVL_W-1:0] o_rx_level
);
  rx_buf_if rx_buf ();

  logic [EVT_W-1:0] raw;
  logic [EVT_W-1:0] mask;
  logic internal_enable;
  logic irq;
  logic [REG_W-1:0] rdata;
  logic [BYTE_W-1:0] rx_data;
  logic [LVL_W-1:0] rx_level;
  logic [EVT_W-1:0] next_raw;
  logic [EVT_W-1:0] next_mask;
  logic next_internal_enable;
  logic next_irq;
  logic [REG_W-1:0] next_rdata;
  logic [BYTE_W-1:0] next_rx_data;
  logic [LVL_W-1:0] next_rx_level;
  logic data_rd_empty;
  logic push_when_full;

  rx_event_buffer u_rx_buf (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .buf_port(rx_buf.owner)
  );

  // Buffer feed; general call data lands here too
  assign rx_buf.push = i_rx_byte_valid;
  assign rx_buf.push_data = i_rx_byte;
  assign rx_buf.pop = i_data_command_register_rd;
  assign rx_buf.flush = !i_ctrl_enable;

  // Set wins over clear on every sticky bit
  function automatic logic sticky_next(
    input logic cur,
    input logic clr_ev,
    input logic set_ev
  );
    sticky_next = set_ev || (cur && !clr_ev);
  endfunction : sticky_next

  // Internal enable falls only once engines are idle
  always_comb begin
    next_internal_enable = internal_enable;
    if (i_ctrl_enable) begin
      next_internal_enable = 1'b1;
    end else if (i_engines_idle) begin
      next_internal_enable = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      internal_enable <= 1'b0;
    end else begin
      internal_enable <= next_internal_enable;
    end
  end

  // Event flags
  always_comb begin
    data_rd_empty = i_data_command_register_rd && rx_buf.empty;
    push_when_full = i_rx_byte_valid && rx_buf.full && i_ctrl_enable;

    next_raw = raw;
    next_raw[RX_THRESH_BIT] = i_ctrl_enable
      && (rx_buf.level >= i_receive_threshold_level);

    // Overflow and underflow survive until internal enable drops
    next_raw[RX_OVER_BIT] = sticky_next(raw[RX_OVER_BIT], !internal_enable,
      push_when_full);
    next_raw[RX_UNDER_BIT] = sticky_next(raw[RX_UNDER_BIT], !internal_enable,
      data_rd_empty);

    // Bits 8..3 pass through from the transmit side
    next_raw[TX_SIDE_HI_BIT:TX_SIDE_LO_BIT] = i_tx_side_raw;

    next_raw[GENERAL_CALL_BIT] = sticky_next(raw[GENERAL_CALL_BIT],
      !internal_enable || i_general_call_clear_register_rd, i_general_call_ack);
    next_raw[START_SEEN_BIT] = sticky_next(raw[START_SEEN_BIT],
      !internal_enable || i_start_clear_rd, i_start_condition);
    next_raw[STOP_SEEN_BIT] = sticky_next(raw[STOP_SEEN_BIT],
      !internal_enable || i_stop_clear_rd, i_stop_condition);
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      raw <= '0;
    end else begin
      raw <= next_raw;
    end
  end

  always_comb begin
    next_mask = mask;
    if (i_reg_wr && (i_reg_addr == ENABLE_MASK_ADDR)) begin
      next_mask = i_reg_wdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mask <= ENABLE_MASK_RESET;
    end else begin
      mask <= next_mask;
    end
  end

  // Irq follows the masked word of the same edge
  always_comb begin
    next_irq = |(next_raw & next_mask);
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  always_comb begin
    next_rdata = rdata;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        MASKED_STATUS_ADDR: next_rdata = widen_evt(raw & mask);
        ENABLE_MASK_ADDR: next_rdata = widen_evt(mask);
        RAW_STATUS_ADDR: next_rdata = widen_evt(raw);
        default: next_rdata = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Popped byte captured only when data is present
  always_comb begin
    next_rx_data = rx_data;
    if (i_data_command_register_rd && !rx_buf.empty && i_ctrl_enable) begin
      next_rx_data = rx_buf.pop_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_data <= '0;
    end else begin
      rx_data <= next_rx_data;
    end
  end

  always_comb begin
    next_rx_level = rx_buf.level;
  end

  // Level mirrors the buffer one edge late
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_level <= '0;
    end else begin
      rx_level <= next_rx_level;
    end
  end

  assign o_reg_rdata = rdata;
  assign o_internal_enable_signal = internal_enable;
  assign o_rx_data = rx_data;
  assign o_irq = irq;
  assign o_rx_level = rx_level;
endmodule : i2c_interrupt_status_mask

// ===== core/i2c_evt_pkg.sv
package i2c_evt_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned REG_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned RX_DEPTH = 32;
  localparam int unsigned PTR_W = 5;
  localparam int unsigned LVL_W = 6;
  localparam int unsigned EVT_W = 12;
  localparam logic [LVL_W-1:0] RX_DEPTH_LVL = 6'h20;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] MASKED_STATUS_ADDR = 32'h5000132C;
  localparam logic [ADDR_W-1:0] ENABLE_MASK_ADDR = 32'h50001330;
  localparam logic [ADDR_W-1:0] RAW_STATUS_ADDR = 32'h50001334;

  // Event bit positions
  localparam int unsigned RX_UNDER_BIT = 0;
  localparam int unsigned RX_OVER_BIT = 1;
  localparam int unsigned RX_THRESH_BIT = 2;
  localparam int unsigned TX_SIDE_LO_BIT = 3;
  localparam int unsigned TX_SIDE_HI_BIT = 8;
  localparam int unsigned STOP_SEEN_BIT = 9;
  localparam int unsigned START_SEEN_BIT = 10;
  localparam int unsigned GENERAL_CALL_BIT = 11;
  localparam int unsigned TX_SIDE_W = 6;

  // Reset values
  localparam logic [EVT_W-1:0] ENABLE_MASK_RESET = 12'h8FF;
  localparam logic [REG_W-1:0] READ_ZERO = 16'h0000;

  function automatic logic [REG_W-1:0] widen_evt(input logic [EVT_W-1:0] v);
    widen_evt = {4'h0, v};
  endfunction : widen_evt
endpackage : i2c_evt_pkg

// ===== core/rx_buf_if.sv
`timescale 1ns/1ps
interface rx_buf_if;
  import i2c_evt_pkg::*;
  logic push;
  logic [BYTE_W-1:0] push_data;
  logic pop;
  logic flush;
  logic [BYTE_W-1:0] pop_data;
  logic [LVL_W-1:0] level;
  logic empty;
  logic full;

  modport owner (
    input push, push_data, pop, flush,
    output pop_data, level, empty, full
  );
  modport user (
    output push, push_data, pop, flush,
    input pop_data, level, empty, full
  );
endinterface : rx_buf_if

// ===== core/rx_event_buffer.sv
`timescale 1ns/1ps
module rx_event_buffer
  import i2c_evt_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Buffer port
  rx_buf_if.owner buf_port
);
  logic [BYTE_W-1:0] mem [RX_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [LVL_W-1:0] level;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [LVL_W-1:0] next_level;
  logic do_push;
  logic do_pop;

  always_comb begin
    do_push = buf_port.push && (level != RX_DEPTH_LVL) && !buf_port.flush;
    do_pop = buf_port.pop && (level != '0) && !buf_port.flush;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_level = level;
    if (buf_port.flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_level = '0;
    end else begin
      if (do_push) begin
        next_wr_ptr = wr_ptr + PTR_W'(1);
      end
      if (do_pop) begin
        next_rd_ptr = rd_ptr + PTR_W'(1);
      end
      if (do_push && !do_pop) begin
        next_level = level + LVL_W'(1);
      end else if (do_pop && !do_push) begin
        next_level = level - LVL_W'(1);
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
    end
  end

  // Storage has no reset
  always_ff @(posedge i_core_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= buf_port.push_data;
    end
  end

  assign buf_port.pop_data = mem[rd_ptr];
  assign buf_port.level = level;
  assign buf_port.empty = (level == '0);
  assign buf_port.full = (level == RX_DEPTH_LVL);
endmodule : rx_event_buffer

// ===== verif/i2c_ism_props.sv
`timescale 1ns/1ps
module i2c_ism_props
  import i2c_evt_pkg::*;
(
  // Watched ports
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [REG_W-1:0] i_reg_wdata,
  input wire logic [REG_W-1:0] o_reg_rdata,
  input wire logic i_ctrl_enable,
  input wire logic i_engines_idle,
  input wire logic o_internal_enable_signal,
  input wire logic i_rx_byte_valid,
  input wire logic o_irq,
  input wire logic [LVL_W-1:0] o_rx_level
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic mapped;
  assign mapped = i_reg_addr inside {MASKED_STATUS_ADDR, ENABLE_MASK_ADDR, RAW_STATUS_ADDR};
  top_zero_a: assert property (i_reg_rd |=> o_reg_rdata[15:12] == 4'h0)
    else $error("reserved read bits not zero");
  ien_rise_a: assert property (i_ctrl_enable |=> o_internal_enable_signal)
    else $error("internal enable did not rise");
  ien_fall_a: assert property (!i_ctrl_enable && i_engines_idle |=> !o_internal_enable_signal)
    else $error("internal enable did not fall");
  ien_hold_a: assert property (!i_ctrl_enable && !i_engines_idle && o_internal_enable_signal
    |=> o_internal_enable_signal)
    else $error("internal enable fell while busy");
  flush_level_a: assert property (!i_ctrl_enable |=> ##1 o_rx_level == 6'h00)
    else $error("buffer not flushed");
  level_cap_a: assert property (o_rx_level <= RX_DEPTH_LVL)
    else $error("buffer level above depth");
  irq_masked_a: assert property (i_reg_rd && i_reg_addr == MASKED_STATUS_ADDR
    |=> (o_reg_rdata != 16'h0000) == $past(o_irq))
    else $error("irq disagrees with masked status");
  mask_rw_a: assert property (i_reg_wr && i_reg_addr == ENABLE_MASK_ADDR ##1 i_reg_rd && i_reg_addr == ENABLE_MASK_ADDR
    |=> o_reg_rdata == ($past(i_reg_wdata, 2) & 16'h0FFF))
    else $error("mask readback wrong");
  unmapped_zero_a: assert property (i_reg_rd && !mapped |=> o_reg_rdata == READ_ZERO)
    else $error("unmapped read not zero");
  cover property (i_rx_byte_valid && o_rx_level == RX_DEPTH_LVL);
  cover property (o_irq);
  cover property (!i_ctrl_enable && !i_engines_idle && o_internal_enable_signal);
endmodule : i2c_ism_props
bind i2c_interrupt_status_mask i2c_ism_props u_chk (.i_core_clk, .i_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd,
  .i_reg_wdata, .o_reg_rdata, .i_ctrl_enable, .i_engines_idle, .o_internal_enable_signal, .i_rx_byte_valid,
  .o_irq, .o_rx_level);

// ===== verif/i2c_far_end.sv
`timescale 1ns/1ps
module i2c_far_end
  import i2c_evt_pkg::*;
(
  // Clock
  input wire logic i_core_clk,
  // Bus events toward the device
  output logic o_byte_valid,
  output logic [BYTE_W-1:0] o_byte,
  output logic o_gc,
  output logic o_start,
  output logic o_stop
);
  initial begin
    {o_byte_valid, o_gc, o_start, o_stop} = 4'h0;
    o_byte = 8'h00;
  end
  // Byte line shows junk once released
  task automatic send(input logic [BYTE_W-1:0] b);
    o_byte = b;
    o_byte_valid = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_byte_valid = 1'b0;
    o_byte = ~b;
    @(posedge i_core_clk);
    #1;
  endtask : send
  // 0 stop, 1 start, 2 general call
  task automatic cond(input int k);
    if (k == 0) o_stop = 1'b1;
    else if (k == 1) o_start = 1'b1;
    else o_gc = 1'b1;
    @(posedge i_core_clk);
    #1;
    {o_stop, o_start, o_gc} = 3'h0;
  endtask : cond
endmodule : i2c_far_end

// ===== verif/tb_i2c_interrupt_status_mask.sv
`timescale 1ns/1ps
module tb_i2c_interrupt_status_mask;
  import i2c_evt_pkg::*;
  logic i_core_clk = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0, o_internal_enable_signal, o_irq;
  logic [ADDR_W-1:0] i_reg_addr = '0;
  logic [REG_W-1:0] i_reg_wdata = '0, o_reg_rdata;
  logic i_ctrl_enable = 0, i_engines_idle = 1, i_data_command_register_rd = 0;
  logic [LVL_W-1:0] i_receive_threshold_level = 6'h02, o_rx_level;
  logic i_rx_byte_valid, i_general_call_ack, i_start_condition, i_stop_condition;
  logic [BYTE_W-1:0] i_rx_byte, o_rx_data;
  logic i_general_call_clear_register_rd = 0, i_start_clear_rd = 0, i_stop_clear_rd = 0;
  logic [TX_SIDE_W-1:0] i_tx_side_raw = '0;
  int err_total = 0, checks_done = 0, ticks = 0;
  i2c_interrupt_status_mask dut (.i_core_clk, .i_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
    .o_reg_rdata, .i_ctrl_enable, .i_engines_idle, .i_receive_threshold_level, .o_internal_enable_signal,
    .i_rx_byte_valid, .i_rx_byte, .i_data_command_register_rd, .o_rx_data, .i_general_call_ack,
    .i_start_condition, .i_stop_condition, .i_general_call_clear_register_rd, .i_start_clear_rd,
    .i_stop_clear_rd, .i_tx_side_raw, .o_irq, .o_rx_level);
  i2c_far_end far (.i_core_clk, .o_byte_valid(i_rx_byte_valid), .o_byte(i_rx_byte),
    .o_gc(i_general_call_ack), .o_start(i_start_condition), .o_stop(i_stop_condition));
  initial forever #50 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    ticks++;
    if (ticks == 3000) begin
      err_total++;
      test_done();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : cyc
  task automatic cmp(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    cyc(1);
    i_reg_rd = 1'b0;
    cyc(1);
    cmp(o_reg_rdata, e);
  endtask : rd
  task automatic wr(input logic [REG_W-1:0] d);
    i_reg_addr = ENABLE_MASK_ADDR;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    cyc(1);
    i_reg_wr = 1'b0;
  endtask : wr
  task automatic pls(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(2);
  endtask : pls
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  initial begin
    logic [REG_W-1:0] acc;
    cyc(8);
    i_rst = 0;
    cyc(1);
    rd(ENABLE_MASK_ADDR, 16'h08FF);
    rd(RAW_STATUS_ADDR, 16'h0000);
    rd(32'h50001338, 16'h0000);
    wr(16'hFFFF);
    rd(ENABLE_MASK_ADDR, 16'h0FFF);
    $display("mask test done");
    i_ctrl_enable = 1;
    cyc(2);
    far.send(8'hA1);
    cyc(3);
    rd(RAW_STATUS_ADDR, 16'h0000);
    far.send(8'hA2);
    cyc(3);
    rd(RAW_STATUS_ADDR, 16'h0004);
    pls(i_data_command_register_rd);
    cmp({8'h00, o_rx_data}, 16'h00A1);
    rd(RAW_STATUS_ADDR, 16'h0000);
    far.send(8'hA3);
    cyc(3);
    i_engines_idle = 0;
    i_ctrl_enable = 0;
    cyc(2);
    rd(RAW_STATUS_ADDR, 16'h0000);
    $display("threshold test done");
    i_engines_idle = 1;
    i_ctrl_enable = 1;
    cyc(2);
    pls(i_data_command_register_rd);
    rd(RAW_STATUS_ADDR, 16'h0001);
    i_engines_idle = 0;
    i_ctrl_enable = 0;
    cyc(3);
    rd(RAW_STATUS_ADDR, 16'h0001);
    i_engines_idle = 1;
    cyc(3);
    rd(RAW_STATUS_ADDR, 16'h0000);
    $display("underflow test done");
    i_ctrl_enable = 1;
    i_receive_threshold_level = 6'h20;
    cyc(2);
    repeat (32) far.send(8'h5A);
    far.send(8'hC3);
    cyc(3);
    rd(RAW_STATUS_ADDR, 16'h0006);
    cmp({10'h000, o_rx_level}, 16'h0020);
    acc = 16'h0006;
    for (int k = 0; k < 3; k++) begin
      far.cond(k);
      cyc(2);
      acc = acc | (16'h0200 << k);
      rd(RAW_STATUS_ADDR, acc);
    end
    pls(i_general_call_clear_register_rd);
    rd(RAW_STATUS_ADDR, 16'h0606);
    pls(i_stop_clear_rd);
    rd(RAW_STATUS_ADDR, 16'h0406);
    $display("event test done");
    i_tx_side_raw = 6'h3F;
    wr(16'h0400);
    cyc(3);
    rd(MASKED_STATUS_ADDR, 16'h0400);
    cmp({15'h0000, o_irq}, 16'h0001);
    rd(RAW_STATUS_ADDR, 16'h05FE);
    wr(16'h0000);
    cyc(3);
    cmp({15'h0000, o_irq}, 16'h0000);
    rd(MASKED_STATUS_ADDR, 16'h0000);
    pls(i_start_clear_rd);
    rd(RAW_STATUS_ADDR, 16'h01FE);
    pls(i_data_command_register_rd);
    cmp({8'h00, o_rx_data}, 16'h005A);
    i_ctrl_enable = 0;
    cyc(3);
    rd(RAW_STATUS_ADDR, 16'h01F8);
    $display("masking test done");
    test_done();
  end
endmodule : tb_i2c_interrupt_status_mask
